// file: logic/acc_defines.svh
// Register map, field positions and timing constants of the comparator block.
// Contract
// - Writes protected except start and flag registers
// - Debugger writes bypass write protection
// - Result is one when positive exceeds negative
// - Event config frozen while module enabled
// - Comparator settings frozen while comparator enabled
// - Comparator runs only with both enables set
// - Module disable stops comparators, keeps their enables
// - Soft reset clears all but debug, disables
// - Start-up delay before result, continuous first only
// - Low-power mux bit switches doubler off
// - Interrupt select: toggle, rise, fall, end
// - Output events follow state regardless of interrupts
// - Continuous: update state, first sets ready
// - Continuous edges compare current and previous sample
// - Sleep toggle requests clock, then releases it
// - Single-shot: start, delay, one comparison
// - Start clears ready, completion sets it
// - Trigger read starts shots, stalls until ready
// - Event input starts shot, clears ready
// - Single-shot edges compare consecutive results
// - Sleep event shot runs then stops clock
// - Logic keeps running during debug halt
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH

`define ACC_OFF_MAIN    12'h000
`define ACC_OFF_START   12'h004
`define ACC_OFF_EVCFG   12'h008
`define ACC_OFF_IRQMSK  12'h00c
`define ACC_OFF_IRQFLG  12'h010
`define ACC_OFF_STATE   12'h014
`define ACC_OFF_READY   12'h018
`define ACC_OFF_TRIG    12'h01c
`define ACC_OFF_CFG0    12'h020
`define ACC_OFF_CFG1    12'h024
`define ACC_OFF_DBG     12'h028

`define ACC_MAIN_SOFT_RESET_BIT  0
`define ACC_MAIN_EN     1
`define ACC_MAIN_LOW_POWER_MUX_BIT  2
`define ACC_EV_OUT_LSB  0
`define ACC_EV_IN_LSB   8

`define ACC_CFG_EN      0
`define ACC_CFG_SINGLE  2
`define ACC_CFG_SPEED   3
`define ACC_CFG_ISEL    4
`define ACC_CFG_HYSTERESIS_SELECT    6
`define ACC_CFG_POS     8
`define ACC_CFG_NEG     12
`define ACC_CFG_FILTER_LENGTH    24

`define ACC_CLK_MHZ     50
`define ACC_STARTUP_NS  2000
`define ACC_DOUBLER_NS  3000
`define ACC_NS2CYC(ns)  (((ns) * `ACC_CLK_MHZ + 999) / 1000)

`endif

// file: logic/acc_pkg.sv
// Types shared by the comparator control block.
package acc_pkg;

    typedef enum logic [1:0] {
        ACC_ISEL_TOGGLE,
        ACC_ISEL_RISE,
        ACC_ISEL_FALL,
        ACC_ISEL_EOC
    } acc_isel_e;

    typedef struct packed {
        logic [2:0] filter_length;
        logic [2:0] negative_input_select;
        logic [1:0] positive_input_select;
        logic       hysteresis_select;
        acc_isel_e  irq_condition_select;
        logic       speed;
        logic       single;
        logic       enable;
    } acc_cfg_s;

    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_WAIT,
        ACC_CMP
    } acc_state_e;

endpackage

// file: logic/acc_comparator_module.sv
// Digital control of two analog comparators with an APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "acc_defines.svh"

module acc_comparator_module
    import acc_pkg::*;
#(
    parameter int SAMPLE_DIV = 4,
    parameter int NCMP       = 2
) (
    input  wire logic            sys_clk,
    input  wire logic            rstn,
    input  wire logic [11:0]     paddr,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire logic            wp_enable,
    input  wire logic            dbg_access,
    input  wire logic [NCMP-1:0] cmp_raw,
    input  wire logic [NCMP-1:0] evt_start,
    output logic      [NCMP-1:0] evt_out,
    output logic      [NCMP-1:0] cmp_power,
    output acc_cfg_s             cmp_cfg [NCMP],
    output logic                 doubler_en,
    input  wire logic            sleep_mode,
    output logic                 clk_request,
    output logic                 irq
);

    localparam logic [11:0] SU_CYC = 12'(`ACC_NS2CYC(`ACC_STARTUP_NS));
    localparam logic [11:0] DB_CYC = 12'(`ACC_NS2CYC(`ACC_DOUBLER_NS));
    localparam logic [7:0]  SDIV   = 8'(SAMPLE_DIV - 1);

    logic            main_en;
    logic            lp_mux;
    logic            dbg_run;
    logic [NCMP-1:0] ev_out_en;
    logic [NCMP-1:0] ev_in_en;
    logic [NCMP-1:0] irq_mask;
    logic [NCMP-1:0] irq_flag;
    acc_cfg_s        cfg [NCMP];
    logic [NCMP-1:0] cmp_s1;
    logic [NCMP-1:0] cmp_s2;
    logic [NCMP-1:0] cmp_s3;
    logic [NCMP-1:0] cmp_f;
    logic [7:0]      div_cnt;
    logic            tick;
    logic [NCMP-1:0] state_bits;
    logic [NCMP-1:0] ready_bits;
    logic [NCMP-1:0] busy_bits;
    logic [NCMP-1:0] irq_set;
    logic [NCMP-1:0] toggle_pend;
    logic [NCMP-1:0] shot_busy;
    logic            wr_ok;
    logic            prot_hit;
    logic            sreset;
    logic            trig_setup;
    logic            trig_wait;
    logic            mapped;
    logic            trig_ld;

    // True for a completing write to the given offset.
    function automatic logic wr_to(input logic [11:0] off);
        wr_to = wr_ok && (paddr == off);
    endfunction

    // Offsets reached by every master regardless of protection.
    function automatic logic unprot(input logic [11:0] off);
        unprot = (off == `ACC_OFF_START) || (off == `ACC_OFF_IRQFLG);
    endfunction

    // Protection blocks ordinary masters only; debugger writes pass.
    assign prot_hit = wp_enable && !dbg_access && !unprot(paddr);
    assign mapped   = (paddr <= `ACC_OFF_DBG) && (paddr[1:0] == 2'b00);
    assign wr_ok    = psel && penable && pwrite && pready && mapped
                      && !prot_hit;
    assign sreset   = wr_to(`ACC_OFF_MAIN) && pwdata[`ACC_MAIN_SOFT_RESET_BIT];

    // A trigger read starts shots in its setup cycle and waits in access.
    assign trig_setup = psel && !penable && !pwrite
                        && (paddr == `ACC_OFF_TRIG);
    assign trig_wait  = psel && penable && !pwrite
                        && (paddr == `ACC_OFF_TRIG);
    assign pready  = !trig_wait || trig_ld;
    assign pslverr = psel && penable && pready
                     && (!mapped || (pwrite && prot_hit));

    // The trigger answer is loaded on the same edge at which pready rises.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            trig_ld <= 1'b0;
        end else begin
            trig_ld <= trig_wait && !trig_ld && !(|busy_bits);
        end
    end

    // Main control; soft reset returns it to the disabled state.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            main_en <= 1'b0;
            lp_mux  <= 1'b0;
        end else if (sreset) begin
            main_en <= 1'b0;
            lp_mux  <= 1'b0;
        end else if (wr_to(`ACC_OFF_MAIN)) begin
            main_en <= pwdata[`ACC_MAIN_EN];
            lp_mux  <= pwdata[`ACC_MAIN_LOW_POWER_MUX_BIT];
        end
    end

    // Debug control survives soft reset; comparators never halt for debug.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            dbg_run <= 1'b0;
        end else if (wr_to(`ACC_OFF_DBG) && !main_en) begin
            dbg_run <= pwdata[0];
        end
    end

    // Event configuration accepts writes only while the module is off.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ev_out_en <= '0;
            ev_in_en  <= '0;
        end else if (sreset) begin
            ev_out_en <= '0;
            ev_in_en  <= '0;
        end else if (wr_to(`ACC_OFF_EVCFG) && !main_en) begin
            ev_out_en <= pwdata[`ACC_EV_OUT_LSB +: NCMP];
            ev_in_en  <= pwdata[`ACC_EV_IN_LSB +: NCMP];
        end
    end

    // Interrupt mask.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq_mask <= '0;
        end else if (sreset) begin
            irq_mask <= '0;
        end else if (wr_to(`ACC_OFF_IRQMSK)) begin
            irq_mask <= pwdata[NCMP-1:0];
        end
    end

    // Sticky flags: a new event in the clearing cycle keeps the flag set.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq_flag <= '0;
        end else if (sreset) begin
            irq_flag <= '0;
        end else if (wr_to(`ACC_OFF_IRQFLG)) begin
            irq_flag <= (irq_flag & ~pwdata[NCMP-1:0]) | irq_set;
        end else begin
            irq_flag <= irq_flag | irq_set;
        end
    end

    assign irq = |(irq_flag & irq_mask);

    // Three-stage synchroniser; a change counts once stages two and three
    // agree, so software only ever sees settled comparator levels.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cmp_s1 <= '0;
            cmp_s2 <= '0;
            cmp_s3 <= '0;
        end else begin
            cmp_s1 <= cmp_raw;
            cmp_s2 <= cmp_s1;
            cmp_s3 <= cmp_s2;
        end
    end

    // Settled comparator levels.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cmp_f <= '0;
        end else begin
            cmp_f <= (cmp_s2 & cmp_s3) | (cmp_f & (cmp_s2 | cmp_s3));
        end
    end

    // Sampling tick; it runs free and ignores any debug halt.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            div_cnt <= '0;
        end else if (div_cnt == SDIV) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    assign tick = (div_cnt == SDIV);

    // Per-comparator configuration, sequencing and result logic.
    for (genvar i = 0; i < NCMP; i++) begin : g_cmp
        acc_state_e st;
        logic [11:0] cnt;
        logic        st_bit;
        logic        rdy;
        logic        active;
        logic        trig;
        logic        done;
        logic        rise;
        logic        fall;
        logic        hit;
        logic [11:0] off;

        assign off = i[0] ? `ACC_OFF_CFG1 : `ACC_OFF_CFG0;

        // Settings other than the enable bit are writable only while this comparator is disabled.
        always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
                cfg[i] <= '0;
            end else if (sreset) begin
                cfg[i] <= '0;
            end else if (wr_to(off)) begin
                cfg[i].enable <= pwdata[`ACC_CFG_EN];
                if (!cfg[i].enable) begin
                    cfg[i].single <= pwdata[`ACC_CFG_SINGLE];
                    cfg[i].speed  <= pwdata[`ACC_CFG_SPEED];
                    cfg[i].irq_condition_select <=
                        acc_isel_e'(pwdata[`ACC_CFG_ISEL +: 2]);
                    cfg[i].hysteresis_select <= pwdata[`ACC_CFG_HYSTERESIS_SELECT];
                    cfg[i].positive_input_select <=
                        pwdata[`ACC_CFG_POS +: 2];
                    cfg[i].negative_input_select <=
                        pwdata[`ACC_CFG_NEG +: 3];
                    cfg[i].filter_length <= pwdata[`ACC_CFG_FILTER_LENGTH +: 3];
                end
            end
        end

        assign active = main_en && cfg[i].enable;
        assign trig = (wr_to(`ACC_OFF_START) && pwdata[i])
                      || (evt_start[i] && ev_in_en[i])
                      || trig_setup;
        assign done = (st == ACC_CMP) && tick && active;

        // Idle, start-up wait, then compare; continuous stays comparing.
        always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
                st  <= ACC_IDLE;
                cnt <= '0;
            end else if (sreset || !active) begin
                st  <= ACC_IDLE;
                cnt <= '0;
            end else begin
                case (st)
                    ACC_IDLE: begin
                        if (!cfg[i].single || trig) begin
                            st  <= ACC_WAIT;
                            cnt <= lp_mux ? SU_CYC : SU_CYC + DB_CYC;
                        end
                    end
                    ACC_WAIT: begin
                        if (cnt <= 12'h001) begin
                            st <= ACC_CMP;
                        end
                        cnt <= cnt - 12'h001;
                    end
                    ACC_CMP: begin
                        if (tick && cfg[i].single) begin
                            st <= ACC_IDLE;
                        end
                    end
                    default: st <= ACC_IDLE;
                endcase
            end
        end

        // Result and ready; the previous result feeds the edge detector.
        always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
                st_bit <= 1'b0;
                rdy    <= 1'b0;
            end else if (sreset) begin
                st_bit <= 1'b0;
                rdy    <= 1'b0;
            end else if (done) begin
                st_bit <= cmp_f[i];
                rdy    <= 1'b1;
            end else if (!active) begin
                rdy <= 1'b0;
            end else if (st == ACC_IDLE && trig && cfg[i].single) begin
                rdy <= 1'b0;
            end
        end

        // Edges compare the new result with the one before it.
        assign rise = done && cmp_f[i] && !st_bit;
        assign fall = done && !cmp_f[i] && st_bit;

        // Interrupt condition selection.
        always_comb begin
            case (cfg[i].irq_condition_select)
                ACC_ISEL_TOGGLE: hit = rise || fall;
                ACC_ISEL_RISE:   hit = rise;
                ACC_ISEL_FALL:   hit = fall;
                default:         hit = done;
            endcase
        end

        assign irq_set[i]     = hit;
        assign state_bits[i]  = st_bit;
        assign ready_bits[i]  = rdy;
        assign busy_bits[i]   = active && !rdy;
        assign toggle_pend[i] = (st == ACC_CMP) && !cfg[i].single
                                && (cmp_f[i] != st_bit);
        assign shot_busy[i]   = cfg[i].single && (st != ACC_IDLE);
        assign cmp_power[i]   = active && (st != ACC_IDLE);
        assign cmp_cfg[i]     = cfg[i];
    end

    // Events follow the result whether or not interrupts are enabled.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            evt_out <= '0;
        end else begin
            evt_out <= state_bits & ev_out_en;
        end
    end

    // Doubler runs while any comparator is powered, unless bypassed.
    assign doubler_en = (|cmp_power) && !lp_mux;

    // In sleep the clock is held only while work or a wake-up is pending.
    assign clk_request = !sleep_mode || (|toggle_pend) || (|shot_busy)
                         || irq;

    // Read data mux.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= '0;
            if (paddr == `ACC_OFF_MAIN) begin
                prdata[`ACC_MAIN_EN]    <= main_en;
                prdata[`ACC_MAIN_LOW_POWER_MUX_BIT] <= lp_mux;
            end else if (paddr == `ACC_OFF_EVCFG) begin
                prdata[`ACC_EV_OUT_LSB +: NCMP] <= ev_out_en;
                prdata[`ACC_EV_IN_LSB +: NCMP]  <= ev_in_en;
            end else if (paddr == `ACC_OFF_IRQMSK) begin
                prdata[NCMP-1:0] <= irq_mask;
            end else if (paddr == `ACC_OFF_IRQFLG) begin
                prdata[NCMP-1:0] <= irq_flag;
            end else if (paddr == `ACC_OFF_STATE) begin
                prdata[NCMP-1:0] <= state_bits;
            end else if (paddr == `ACC_OFF_READY) begin
                prdata[NCMP-1:0] <= ready_bits;
            end else if (paddr == `ACC_OFF_CFG0) begin
                prdata <= 32'(cfg_word(cfg[0]));
            end else if (paddr == `ACC_OFF_CFG1) begin
                prdata <= 32'(cfg_word(cfg[1]));
            end else if (paddr == `ACC_OFF_DBG) begin
                prdata[0] <= dbg_run;
            end
        end else if (trig_wait && !trig_ld) begin
            prdata <= {{(32-NCMP){1'b0}}, state_bits};
        end
    end

    // Places a configuration into its register layout.
    function automatic logic [31:0] cfg_word(input acc_cfg_s c);
        cfg_word = '0;
        cfg_word[`ACC_CFG_EN]        = c.enable;
        cfg_word[`ACC_CFG_SINGLE]    = c.single;
        cfg_word[`ACC_CFG_SPEED]     = c.speed;
        cfg_word[`ACC_CFG_ISEL +: 2] = c.irq_condition_select;
        cfg_word[`ACC_CFG_HYSTERESIS_SELECT]      = c.hysteresis_select;
        cfg_word[`ACC_CFG_POS +: 2]  = c.positive_input_select;
        cfg_word[`ACC_CFG_NEG +: 3]  = c.negative_input_select;
        cfg_word[`ACC_CFG_FILTER_LENGTH +: 3] = c.filter_length;
    endfunction

endmodule // acc_comparator_module

`default_nettype wire

// file: test/acc_checker_sva.sv
// Port-level checker of the comparator control block, with its bind.
`timescale 1ns/100ps
`default_nettype none
`include "acc_defines.svh"

module acc_checker
    import acc_pkg::*;
#(
    parameter int SAMPLE_DIV = 4,
    parameter int NCMP       = 2
) (
    input  wire logic            sys_clk,
    input  wire logic            rstn,
    input  wire logic [11:0]     paddr,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic            pready,
    input  wire logic            pslverr,
    input  wire logic            wp_enable,
    input  wire logic            dbg_access,
    input  wire logic [NCMP-1:0] cmp_power,
    input  wire acc_cfg_s        cmp_cfg [NCMP],
    input  wire logic            doubler_en,
    input  wire logic            sleep_mode,
    input  wire logic            clk_request,
    input  wire logic            irq
);
    logic wr_done;

    // A write completes when the access phase sees pready.
    assign wr_done = psel && penable && pready && pwrite;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    wp_block_a: assert property (wr_done && wp_enable && !dbg_access && paddr == `ACC_OFF_MAIN |-> pslverr)
        else $error("protected write accepted");
    wp_exempt_a: assert property (wr_done && wp_enable && (paddr == `ACC_OFF_START || paddr == `ACC_OFF_IRQFLG) |-> !pslverr)
        else $error("exempt write refused");
    dbg_bypass_a: assert property (wr_done && dbg_access && paddr == `ACC_OFF_DBG |-> !pslverr)
        else $error("debugger write refused");
    fast_ready_a: assert property (psel && penable && paddr != `ACC_OFF_TRIG |-> pready)
        else $error("ordinary access stalled");
    trig_stall_a: assert property (psel && penable && !pwrite && paddr == `ACC_OFF_TRIG && !pready |-> ##[1:400] pready)
        else $error("trigger read stalled too long");
    doubler_need_a: assert property (doubler_en |-> |cmp_power)
        else $error("doubler on with no comparator powered");
    power_enable_a: assert property ((cmp_power & ~{cmp_cfg[1].enable, cmp_cfg[0].enable}) == 2'b00)
        else $error("comparator powered while disabled");
    cfg_lock_a: assert property (cmp_cfg[0].enable && $past(cmp_cfg[0].enable) |-> $stable(cmp_cfg[0][13:1]))
        else $error("settings changed while enabled");
    clk_awake_a: assert property (!sleep_mode |-> clk_request)
        else $error("clock released while awake");
    irq_clock_a: assert property (irq |-> clk_request)
        else $error("clock released with interrupt pending");

    cover property (psel && penable && !pready);
    cover property (irq);
    cover property (psel && penable && pslverr);
endmodule // acc_checker

bind acc_comparator_module acc_checker #(
    .SAMPLE_DIV(SAMPLE_DIV),
    .NCMP(NCMP)
) acc_checker_inst (
    .sys_clk(sys_clk), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready),
    .pslverr(pslverr), .wp_enable(wp_enable), .dbg_access(dbg_access),
    .cmp_power(cmp_power), .cmp_cfg(cmp_cfg), .doubler_en(doubler_en),
    .sleep_mode(sleep_mode), .clk_request(clk_request), .irq(irq)
);
`default_nettype wire

// file: test/acc_far_side.sv
// Far-side model: analog comparator levels and incoming event pulses.
`timescale 1ns/100ps
`default_nettype none

module acc_far_side (
    input  wire logic       sys_clk,
    output logic      [1:0] cmp_raw,
    output logic      [1:0] evt_start
);
    // Both comparators start below their thresholds, no event pending.
    initial begin
        cmp_raw = 2'b00;
        evt_start = 2'b00;
    end

    // A level of one means the positive input is above the negative.
    task automatic set_level(input int i, input logic v);
        @(posedge sys_clk);
        cmp_raw[i] <= v;
    endtask

    // An incoming event lasts exactly one clock.
    task automatic pulse_event(input int i);
        @(posedge sys_clk);
        evt_start[i] <= 1'b1;
        @(posedge sys_clk);
        evt_start[i] <= 1'b0;
    endtask
endmodule // acc_far_side
`default_nettype wire

// file: test/tb_top.sv
// Self-checking testbench of the comparator control block.
`timescale 1ns/100ps
`default_nettype none
`include "acc_defines.svh"

module tb_top;
    import acc_pkg::*;
    logic        sys_clk;
    logic        rstn;
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        wp_enable;
    logic        dbg_access;
    logic [1:0]  cmp_raw;
    logic [1:0]  evt_start;
    logic [1:0]  evt_out;
    logic [1:0]  cmp_power;
    acc_cfg_s    cmp_cfg [2];
    logic        doubler_en;
    logic        sleep_mode;
    logic        clk_request;
    logic        irq;
    logic [31:0] rdat;
    logic        rerr;
    int          mismatches = 0;
    int          comparisons = 0;

    acc_comparator_module #(.SAMPLE_DIV(4), .NCMP(2)) acc_comparator_module_inst (
        .sys_clk(sys_clk), .rstn(rstn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wp_enable(wp_enable), .dbg_access(dbg_access), .cmp_raw(cmp_raw),
        .evt_start(evt_start), .evt_out(evt_out), .cmp_power(cmp_power),
        .cmp_cfg(cmp_cfg), .doubler_en(doubler_en), .sleep_mode(sleep_mode),
        .clk_request(clk_request), .irq(irq)
    );
    acc_far_side acc_far_side_inst (
        .sys_clk(sys_clk), .cmp_raw(cmp_raw), .evt_start(evt_start)
    );

    // Free-running 50 MHz clock.
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // Compares one value and reports a mismatch.
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; data and error are taken at the completing edge.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Reads a register and compares the masked value.
    task automatic rd_chk(input string name, input logic [11:0] a,
                          input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(name, rdat & m, exp);
    endtask

    // Polls the ready register until the masked bits are set.
    task automatic wait_ready(input logic [31:0] m);
        do begin
            apb(1'b0, `ACC_OFF_READY, 32'h0);
        end while ((rdat & m) !== m);
    endtask

    // Lets a number of clock edges pass.
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Cuts a hang short well beyond the expected run length.
    initial begin
        #(20 * 60000);
        mismatches++;
        wrap_up();
    end

    // Main test sequence.
    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        wp_enable = 1'b0;
        dbg_access = 1'b0;
        sleep_mode = 1'b0;
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        rd_chk("main reset", `ACC_OFF_MAIN, 32'hffffffff, 32'h0);
        apb(1'b0, 12'h030, 32'h0);
        check("unmapped err", 32'(rerr), 32'h1);
        check("unmapped data", rdat, 32'h0);
        $display("test reset done");
        wp_enable <= 1'b1;
        apb(1'b1, `ACC_OFF_MAIN, 32'h2);
        check("wp err", 32'(rerr), 32'h1);
        rd_chk("wp main", `ACC_OFF_MAIN, 32'hffffffff, 32'h0);
        apb(1'b1, `ACC_OFF_IRQFLG, 32'h3);
        check("flag err", 32'(rerr), 32'h0);
        dbg_access <= 1'b1;
        apb(1'b1, `ACC_OFF_DBG, 32'h1);
        check("dbg err", 32'(rerr), 32'h0);
        dbg_access <= 1'b0;
        wp_enable <= 1'b0;
        rd_chk("dbg reg", `ACC_OFF_DBG, 32'h1, 32'h1);
        $display("test protection done");
        apb(1'b1, `ACC_OFF_CFG0, 32'h11);
        apb(1'b1, `ACC_OFF_EVCFG, 32'h203);
        apb(1'b1, `ACC_OFF_IRQMSK, 32'h3);
        apb(1'b1, `ACC_OFF_MAIN, 32'h2);
        wait_cyc(2);
        check("doubler", 32'(doubler_en), 32'h1);
        wait_ready(32'h1);
        rd_chk("state low", `ACC_OFF_STATE, 32'h1, 32'h0);
        acc_far_side_inst.set_level(0, 1'b1);
        wait_cyc(20);
        rd_chk("state high", `ACC_OFF_STATE, 32'h1, 32'h1);
        rd_chk("rise flag", `ACC_OFF_IRQFLG, 32'h1, 32'h1);
        check("irq set", 32'(irq), 32'h1);
        check("event out", 32'(evt_out[0]), 32'h1);
        apb(1'b1, `ACC_OFF_IRQFLG, 32'h1);
        wait_cyc(2);
        check("irq clear", 32'(irq), 32'h0);
        acc_far_side_inst.set_level(0, 1'b0);
        wait_cyc(20);
        rd_chk("no fall flag", `ACC_OFF_IRQFLG, 32'h1, 32'h0);
        apb(1'b1, `ACC_OFF_CFG0, 32'h15);
        rd_chk("cfg locked", `ACC_OFF_CFG0, 32'hffffffff, 32'h11);
        apb(1'b1, `ACC_OFF_EVCFG, 32'h0);
        rd_chk("evcfg locked", `ACC_OFF_EVCFG, 32'hffffffff, 32'h203);
        apb(1'b1, `ACC_OFF_MAIN, 32'h0);
        wait_cyc(2);
        check("stopped", 32'(cmp_power[0]), 32'h0);
        rd_chk("enable kept", `ACC_OFF_CFG0, 32'h1, 32'h1);
        $display("test continuous done");
        apb(1'b1, `ACC_OFF_CFG1, 32'h35);
        apb(1'b1, `ACC_OFF_MAIN, 32'h6);
        wait_cyc(2);
        check("doubler off", 32'(doubler_en), 32'h0);
        check("shot idle", 32'(cmp_power[1]), 32'h0);
        apb(1'b1, `ACC_OFF_START, 32'h2);
        rd_chk("ready cleared", `ACC_OFF_READY, 32'h2, 32'h0);
        check("shot powered", 32'(cmp_power[1]), 32'h1);
        wait_ready(32'h2);
        rd_chk("end flag", `ACC_OFF_IRQFLG, 32'h2, 32'h2);
        rd_chk("shot state", `ACC_OFF_STATE, 32'h2, 32'h0);
        acc_far_side_inst.set_level(1, 1'b1);
        apb(1'b0, `ACC_OFF_TRIG, 32'h0);
        check("trigger state", rdat & 32'h2, 32'h2);
        acc_far_side_inst.pulse_event(1);
        wait_cyc(2);
        rd_chk("event cleared", `ACC_OFF_READY, 32'h2, 32'h0);
        wait_ready(32'h2);
        rd_chk("event state", `ACC_OFF_STATE, 32'h2, 32'h2);
        $display("test single-shot done");
        apb(1'b1, `ACC_OFF_MAIN, 32'h1);
        wait_cyc(2);
        rd_chk("cfg1 reset", `ACC_OFF_CFG1, 32'hffffffff, 32'h0);
        rd_chk("main cleared", `ACC_OFF_MAIN, 32'hffffffff, 32'h0);
        rd_chk("dbg kept", `ACC_OFF_DBG, 32'h1, 32'h1);
        sleep_mode <= 1'b1;
        wait_cyc(4);
        check("clock released", 32'(clk_request), 32'h0);
        sleep_mode <= 1'b0;
        $display("test soft reset done");
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
